// ---- rtc_pkg.sv ----
// package for the time and date counter block: register map, field layout,
// timing constants and bus carrier types.
// assumes an ahb-lite master with 32-bit data and a single 125 MHz clock.
package rtc_pkg;

    // **********
    // register map (byte addresses, one aligned word each)
    // **********
    localparam logic [7:0] YEAR_MONTH_ADDR  = 8'h00; // year offset and month
    localparam logic [7:0] DAY_WEEKDAY_ADDR = 8'h04; // day and weekday
    localparam logic [7:0] HOUR_MINUTE_ADDR = 8'h08; // hours and minutes
    localparam logic [7:0] SECOND_ADDR      = 8'h0C; // seconds
    localparam logic [7:0] CONTROL_ADDR     = 8'h10; // unlock code and soft reset
    localparam logic [7:0] STATE_ADDR       = 8'h14; // unstable and unlocked flags

    // **********
    // field layout
    // **********
    localparam int YEAR_LSB    = 8;  // year offset in 15:8
    localparam int YEAR_W      = 8;
    localparam int MONTH_W     = 4;  // month in 3:0
    localparam int WEEKDAY_LSB = 8;  // weekday in 10:8
    localparam int WEEKDAY_W   = 3;
    localparam int DAY_W       = 5;  // day in 4:0
    localparam int HOUR_LSB    = 8;  // hours in 12:8
    localparam int HOUR_W      = 5;
    localparam int MINUTE_W    = 6;  // minutes in 5:0
    localparam int SECOND_W    = 6;  // seconds in 5:0
    localparam int UNLOCK_W    = 2;  // unlock code in control 1:0
    localparam int SOFT_RESET_BIT = 8;    // control bit that pulses a soft reset
    localparam int UNSTABLE_BIT   = 0;    // state bit 0
    localparam int UNLOCKED_BIT   = 1;    // state bit 1

    // **********
    // reset and limit values
    // **********
    localparam logic [7:0] YEAR_RESET  = 8'h00;  // base year itself
    localparam logic [3:0] MONTH_RESET = 4'h1;
    localparam logic [4:0] DAY_RESET   = 5'h01;
    localparam logic [3:0] MONTH_LAST  = 4'hC;
    localparam logic [3:0] FEBRUARY    = 4'h2;
    localparam logic [2:0] WEEKDAY_LAST = 3'h6;  // saturday
    localparam logic [4:0] HOUR_LAST   = 5'h17;  // 23
    localparam logic [5:0] MINUTE_LAST = 6'h3B;  // 59
    localparam logic [1:0] UNLOCK_FIRST  = 2'h1; // unlock code, first write
    localparam logic [1:0] UNLOCK_SECOND = 2'h2; // unlock code, second write
    localparam logic [31:0] ERROR_DATA = 32'hFFFFFFFF;

    // **********
    // timing
    // **********
    localparam int CLK_HZ          = 125_000_000;
    localparam int UNLOCK_WINDOW_S = 2;   // window after unlock
    localparam int POWERUP_WINDOW_S = 15; // window after power-on
    localparam int UNSTABLE_CYCLES = 4;   // flag held around each tick

    // **********
    // bus carrier
    // **********
    typedef struct packed {
        logic        write;  // latched hwrite
        logic [7:0]  addr;   // latched low address bits
        logic        valid;  // data phase belongs to a real transfer
    } bus_phase_type;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,  // ready, no pending transfer
        BUS_ERR1  = 3'b010,  // first error cycle, hready low
        BUS_ERR2  = 3'b100   // second error cycle, hready high
    } bus_state_type;

endpackage : rtc_pkg

// ---- rtc_counter_regs.sv ----
// time and date counters behind an ahb-lite register slave.
// assumes one clock, single-word transfers, and a one-second tick derived
// here from the bus clock by a parameterised divider.
// one second is TICK_CYCLES clocks.
// hsize ignored; whole words only.
// counters keep any value written.
//
// Notes on behaviour
// [R1] year is signed offset from 2112
// [R2] month codes 1..12, others reserved
// [R3] month write loads counter directly
// [R4] soft reset keeps month and year
// [R5] weekday 0 sunday to 6 saturday
// [R6] day field low five bits, 1..31
// [R7] software computes and writes the weekday
// [R8] day reads harmless; writes load both
// [R9] soft reset keeps day and weekday
// [R10] hours in 12:8, 0..23
// [R11] minutes in 5:0, 0..59
// [R12] time counters cleared only by power-on
// [R13] seconds low six bits, 0..59
// [R14] reserved bits ignore writes, read zero
// [R15] bad or locked writes give error
// [R16] reserved reads give error, all ones
// [R17] valid reads always accepted
// [R18] all protected except unlock bits; the soft reset bit 8 is also taken while locked
// [R19] bit 0 flags unstable counters
// [R20] software writes only valid values
// [R21] word-aligned registers, 16 bits wide
// [R22] unlock opens two-second write window
// [R23] fifteen-second window after power-on
// [R24] month lengths and leap years handled
// [R25] seconds ripple into all higher counters

module rtc_counter_regs
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES   = CLK_HZ,                    // cycles per second
    parameter int unsigned UNLOCK_CYCLES = UNLOCK_WINDOW_S * CLK_HZ,  // 2 s
    parameter int unsigned POWERUP_CYCLES = POWERUP_WINDOW_S * CLK_HZ // 15 s
) (
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic        HREADY_I,
    input  wire logic [31:0] HWDATA_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic             UNSTABLE_O,
    output logic             SECOND_TICK_O
);

    // **********
    // helpers
    // **********

    // days in a month; leap year when the full year divides by four
    // (2112 does, so offset mod 4 decides; years 2100 and 2200 lie in range and count as leap)
    function automatic logic [4:0] month_days(input logic [3:0] m,
                                              input logic [7:0] yr);
        case (m)
            4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
            FEBRUARY:               month_days = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C; // see [R24]
            default:                month_days = 5'h1F;
        endcase
    endfunction : month_days

    // true for the six mapped word offsets
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == YEAR_MONTH_ADDR) || (a == DAY_WEEKDAY_ADDR) ||
                    (a == HOUR_MINUTE_ADDR) || (a == SECOND_ADDR) ||
                    (a == CONTROL_ADDR) || (a == STATE_ADDR);
    endfunction : is_mapped

    // **********
    // state
    // **********

    // counters
    logic signed [YEAR_W-1:0] year_q;     // year offset from base year
    logic [MONTH_W-1:0]   month_q;        // month counter
    logic [DAY_W-1:0]     day_q;          // day of month
    logic [WEEKDAY_W-1:0] weekday_q;      // weekday counter
    logic [HOUR_W-1:0]    hour_q;         // hours
    logic [MINUTE_W-1:0]  minute_q;       // minutes
    logic [SECOND_W-1:0]  second_q;       // seconds

    // divider and window
    logic [31:0]          tick_cnt_q;     // divider toward the one-second tick
    logic                 tick;           // one-cycle second tick
    logic [31:0]          window_cnt_q;   // remaining write-window cycles
    logic                 unlock_armed_q; // first unlock code seen
    logic                 soft_reset_q;   // soft reset pulse, nothing here clears on it

    // bus side
    bus_phase_type        phase_q;        // latched address phase
    bus_state_type        bus_q;          // error sequencer

    // decode
    logic                 addr_take;      // address phase accepted this cycle
    logic                 wr_ok;          // data phase write lands
    logic                 wr_err;         // data phase write refused
    logic                 rd_err;         // data phase read refused
    logic                 unlocked;       // writes currently allowed

    // read path
    logic [31:0]          rdata;          // read mux

    // **********
    // one-second divider and unstable window
    // **********

    // last count
    assign tick = (tick_cnt_q == TICK_CYCLES - 1);

    // free-running divider; counters move only on its wrap
    // no soft reset here
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            tick_cnt_q <= 32'h00000000;
        end else if (tick) begin
            tick_cnt_q <= 32'h00000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
    end

    // flag stands a few cycles either side of the tick so software can
    // avoid reading a half-rippled value
    // high 2x+1 cycles
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            UNSTABLE_O <= 1'b0;
        end else begin
            UNSTABLE_O <= (tick_cnt_q >= TICK_CYCLES - 1 - UNSTABLE_CYCLES) ||
                          (tick_cnt_q < UNSTABLE_CYCLES);            // see [R19]
        end
    end

    // tick exported as a registered pulse
    // counters moved last cycle
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            SECOND_TICK_O <= 1'b0;
        end else begin
            SECOND_TICK_O <= tick;
        end
    end

    // **********
    // write protection
    // **********

    // open while nonzero
    assign unlocked = (window_cnt_q != 32'h00000000);

    // window opens for 15 s at power-on and 2 s after the code pair;
    // any other code on the unlock bits closes it at once
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            window_cnt_q   <= POWERUP_CYCLES;                        // see [R23]
            unlock_armed_q <= 1'b0;
        end else if (wr_ok && phase_q.addr == CONTROL_ADDR) begin
            // unlock bits accepted even while locked, see [R18]
            if (HWDATA_I[UNLOCK_W-1:0] == UNLOCK_FIRST) begin
                // arm; window shuts
                unlock_armed_q <= 1'b1;
                window_cnt_q   <= 32'h00000000;
            end else if (unlock_armed_q && HWDATA_I[UNLOCK_W-1:0] == UNLOCK_SECOND) begin
                // pair done: open
                unlock_armed_q <= 1'b0;
                window_cnt_q   <= UNLOCK_CYCLES;                     // see [R22]
            end else begin
                // other code locks
                unlock_armed_q <= 1'b0;
                window_cnt_q   <= 32'h00000000;
            end
        end else if (unlocked) begin
            // zero locks
            window_cnt_q <= window_cnt_q - 32'h00000001;
        end
    end

    // soft reset pulse; counters deliberately ignore it
    // nothing reads it yet
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= wr_ok && phase_q.addr == CONTROL_ADDR &&
                            HWDATA_I[SOFT_RESET_BIT];   // see [R4] [R9] [R12]
        end
    end

    // **********
    // ahb-lite slave
    // **********

    // taken while ready
    assign addr_take = HSEL_I && HREADY_I && HTRANS_I[1];

    // data-phase classification; control stays writable while locked
    assign wr_ok  = phase_q.valid && phase_q.write && bus_q == BUS_IDLE &&
                    is_mapped(phase_q.addr) && phase_q.addr != STATE_ADDR &&
                    (unlocked || phase_q.addr == CONTROL_ADDR);
    assign wr_err = phase_q.valid && phase_q.write && !wr_ok;        // see [R15]
    assign rd_err = phase_q.valid && !phase_q.write &&
                    !is_mapped(phase_q.addr);                        // see [R16] [R17]

    // latch the address phase
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            phase_q <= '0;
        end else if (HREADYOUT_O) begin
            // held through errors
            phase_q.valid <= addr_take;
            phase_q.write <= HWRITE_I;
            phase_q.addr  <= {HADDR_I[7:2], 2'b00};
        end
    end

    // two-cycle error response as the bus requires
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            bus_q       <= BUS_IDLE;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (addr_take && HREADYOUT_O) begin
                        // decide next data phase now so outputs stay registered
                        if ((HWRITE_I && (!is_mapped({HADDR_I[7:2], 2'b00}) ||
                             {HADDR_I[7:2], 2'b00} == STATE_ADDR ||
                             (!unlocked && {HADDR_I[7:2], 2'b00} != CONTROL_ADDR))) ||
                            (!HWRITE_I && !is_mapped({HADDR_I[7:2], 2'b00}))) begin
                            bus_q       <= BUS_ERR1;
                            HREADYOUT_O <= 1'b0;
                            HRESP_O     <= 1'b1;
                        end
                    end
                end

                BUS_ERR1: begin
                    bus_q       <= BUS_ERR2;
                    HREADYOUT_O <= 1'b1;
                end

                BUS_ERR2: begin
                    bus_q   <= BUS_IDLE;
                    HRESP_O <= 1'b0;
                end

                default: begin
                    bus_q       <= BUS_IDLE;
                    HREADYOUT_O <= 1'b1;
                    HRESP_O     <= 1'b0;
                end
            endcase
        end
    end

    // read mux; reserved bits come back as zero
    // live address decode
    always_comb begin
        rdata = 32'h00000000;                                        // see [R14] [R21]
        case ({HADDR_I[7:2], 2'b00})
            YEAR_MONTH_ADDR:  rdata = {16'h0000, year_q, 4'h0, month_q};
            DAY_WEEKDAY_ADDR: rdata = {16'h0000, 5'h00, weekday_q, 3'h0, day_q};
            HOUR_MINUTE_ADDR: rdata = {16'h0000, 3'h0, hour_q, 2'h0, minute_q};
            SECOND_ADDR:      rdata = {24'h000000, 2'h0, second_q};
            CONTROL_ADDR:     rdata = 32'h00000000;
            STATE_ADDR:       rdata = {30'h00000000, unlocked, UNSTABLE_O};
            default:          rdata = ERROR_DATA;                    // see [R16]
        endcase
    end

    // read data sampled at the address phase, shown in the data phase;
    // reads never touch any counter, see [R8]
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            HRDATA_O <= 32'h00000000;
        end else if (addr_take && HREADYOUT_O && !HWRITE_I) begin
            // stands till next read
            HRDATA_O <= rdata;
        end
    end

    // **********
    // time counters: a write wins over the tick for the same register
    // **********

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            second_q <= '0;                                          // see [R12]
        end else if (wr_ok && phase_q.addr == SECOND_ADDR) begin
            second_q <= HWDATA_I[SECOND_W-1:0];                      // see [R13]
        end else if (tick) begin
            second_q <= (second_q == MINUTE_LAST) ? '0 : second_q + 1'b1; // see [R25]
        end
    end

    // ripple carries
    logic carry_min;   // seconds wrap this tick
    logic carry_hour;  // minutes wrap too
    logic carry_day;   // hours wrap too
    logic carry_mon;   // day passes month end
    logic carry_year;  // december ends

    assign carry_min  = tick && second_q == MINUTE_LAST;
    assign carry_hour = carry_min && minute_q == MINUTE_LAST;
    assign carry_day  = carry_hour && hour_q == HOUR_LAST;
    assign carry_mon  = carry_day && day_q >= month_days(month_q, year_q);
    assign carry_year = carry_mon && month_q >= MONTH_LAST;

    // hours and minutes
    // write drops carry
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hour_q   <= '0;
            minute_q <= '0;
        end else if (wr_ok && phase_q.addr == HOUR_MINUTE_ADDR) begin
            hour_q   <= HWDATA_I[HOUR_LSB +: HOUR_W];                // see [R10]
            minute_q <= HWDATA_I[MINUTE_W-1:0];                      // see [R11]
        end else begin
            if (carry_min) begin
                minute_q <= (minute_q == MINUTE_LAST) ? '0 : minute_q + 1'b1;
            end
            if (carry_hour) begin
                hour_q <= (hour_q == HOUR_LAST) ? '0 : hour_q + 1'b1;
            end
        end
    end

    // day and weekday; weekday just cycles, it is never derived from the date
    // month end from table
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            day_q     <= DAY_RESET;
            weekday_q <= '0;
        end else if (wr_ok && phase_q.addr == DAY_WEEKDAY_ADDR) begin
            day_q     <= HWDATA_I[DAY_W-1:0];                        // see [R6] [R8]
            weekday_q <= HWDATA_I[WEEKDAY_LSB +: WEEKDAY_W];         // see [R5] [R7]
        end else if (carry_day) begin
            day_q     <= carry_mon ? DAY_RESET : day_q + 1'b1;       // see [R24]
            weekday_q <= (weekday_q >= WEEKDAY_LAST) ? '0 : weekday_q + 1'b1;
        end
    end

    // month and year; values are stored as written, with no validation
    // december rolls the year
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            month_q <= MONTH_RESET;
            year_q  <= YEAR_RESET;
        end else if (wr_ok && phase_q.addr == YEAR_MONTH_ADDR) begin
            month_q <= HWDATA_I[MONTH_W-1:0];                        // see [R2] [R3] [R20]
            year_q  <= HWDATA_I[YEAR_LSB +: YEAR_W];                 // see [R1]
        end else if (carry_mon) begin
            month_q <= carry_year ? MONTH_RESET : month_q + 1'b1;
            if (carry_year) begin
                year_q <= year_q + 8'sh01;   // wraps 127 to -128
            end
        end
    end

endmodule : rtc_counter_regs

// ---- rtc_checker_assertions.sv ----
// checker for the time and date counter block: bus responses, tick and flag.
// assumes it sees the top ports only, with HREADY_I tied to HREADYOUT_O.
module rtc_checker
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 64 // cycles per second
) (
    input wire logic        CLK_I,
    input wire logic        RESETN_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        UNSTABLE_O,
    input wire logic        SECOND_TICK_O
);
    // **********
    // helper logic
    // **********
    logic        taken;  // address phase accepted this cycle
    logic        mapped; // offset lies inside the map
    logic [31:0] gap_q;  // cycles since the last tick
    logic        seen_q; // first tick gives no gap to judge
    assign taken  = HSEL_I && HTRANS_I[1] && HREADY_I && HREADYOUT_O;
    assign mapped = HADDR_I[7:0] < 8'h18;
    // gap count restarts at each tick
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end else if (SECOND_TICK_O) begin
            gap_q  <= 32'h0;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 32'h1;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    // **********
    // assertions
    // **********
    a_err_two_cycle: assert property (
        $rose(HRESP_O) |-> !HREADYOUT_O ##1 (HRESP_O && HREADYOUT_O))
        else $error("error response shape wrong");
    a_wait_only_err: assert property (!HREADYOUT_O |-> HRESP_O)
        else $error("wait state without error");
    a_bad_read_ones: assert property (
        taken && !HWRITE_I && !mapped |=> HRESP_O ##1 HRDATA_O == 32'hFFFFFFFF)
        else $error("unmapped read not refused with all ones");
    a_bad_write_err: assert property (
        taken && HWRITE_I && (!mapped || HADDR_I[7:0] == STATE_ADDR) |=> HRESP_O)
        else $error("bad write not refused");
    a_read_ok: assert property (
        taken && !HWRITE_I && mapped |=> HREADYOUT_O && !HRESP_O)
        else $error("mapped read refused");
    a_high_bits_zero: assert property (
        taken && !HWRITE_I && mapped |=> HRDATA_O[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_ctrl_writable: assert property (
        taken && HWRITE_I && HADDR_I[7:0] == CONTROL_ADDR |=> !HRESP_O)
        else $error("control write refused");
    a_tick_flagged: assert property ($rose(SECOND_TICK_O) |-> UNSTABLE_O)
        else $error("tick outside unstable flag");
    // four cycles either side of the tick cycle; the run cut by reset is skipped
    a_flag_length: assert property (
        $rose(UNSTABLE_O) && seen_q |-> UNSTABLE_O [*8] ##1 UNSTABLE_O ##1 !UNSTABLE_O)
        else $error("unstable flag length wrong");
    a_tick_period: assert property (
        $rose(SECOND_TICK_O) && seen_q |-> gap_q == TICK_CYCLES - 1)
        else $error("tick period wrong");
    c_error: cover property ($rose(HRESP_O));
    c_tick: cover property ($rose(SECOND_TICK_O));
    c_ctrl: cover property (taken && HWRITE_I && HADDR_I[7:0] == CONTROL_ADDR);
endmodule : rtc_checker

bind rtc_counter_regs rtc_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.CLK_I, .RESETN_I,
    .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O,
    .UNSTABLE_O, .SECOND_TICK_O);

// ---- rtc_bus_master_model.sv ----
// ahb-lite master standing in for the cpu, single word transfers only.
// assumes the caller enters xfer just after a rising edge.
module rtc_bus_master_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    output logic             hsel_o,
    output logic      [31:0] haddr_o,
    output logic      [1:0]  htrans_o,
    output logic             hwrite_o,
    output logic      [2:0]  hsize_o,
    output logic      [31:0] hwdata_o
);
    // idle bus at time zero
    initial begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o  = 3'b010;
        hwdata_o = 32'h0;
    end
    // one transfer; waits on hready only, the bench timeout ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel_o   <= 1'b1;
        htrans_o <= 2'b10;
        haddr_o  <= {24'h0, a};
        hwrite_o <= wr;
        hsize_o  <= 3'b010;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        htrans_o <= 2'b00;
        hwdata_o <= d;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        // released data lines show the inverse, never a stale value
        hwdata_o <= ~d;
    endtask : xfer
endmodule : rtc_bus_master_model

// ---- tb_top.sv ----
// self-checking bench for the time and date counter block.
// assumes shortened tick, unlock and power-up counts set below.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;
    logic        CLK_I = 1'b0;    // 125 MHz bus clock
    logic        RESETN_I = 1'b0; // power-on reset
    wire  logic        hsel, hwrite, hready, hresp, unstable, tick;
    wire  logic [31:0] haddr, hwdata, hrdata;
    wire  logic [1:0]  htrans;
    wire  logic [2:0]  hsize;
    logic [33:0] notes[$];  // {is read, error, data} per transfer
    logic        pend = 1'b0; // a data phase is open
    logic [33:0] note;
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          seed = 32'h18ED2A96;
    logic [31:0] r;
    logic [7:0]  yr, ny;
    logic [2:0]  wd, nwd;
    logic [7:0]  yr_t[4] = '{8'h00, 8'h04, 8'h01, 8'h10}; // dec 31, leap, plain, april
    logic [3:0]  mo_t[4] = '{4'hC, 4'h2, 4'h2, 4'h4};
    logic [3:0]  nm_t[4] = '{4'h1, 4'h2, 4'h3, 4'h5};
    logic [4:0]  dy_t[4] = '{5'h1F, 5'h1C, 5'h1C, 5'h1E};
    logic [4:0]  nd_t[4] = '{5'h01, 5'h1D, 5'h01, 5'h01};
    always #4 CLK_I = ~CLK_I;
    rtc_counter_regs #(.TICK_CYCLES(64), .UNLOCK_CYCLES(2000), .POWERUP_CYCLES(40)) dut_u (
        .CLK_I, .RESETN_I, .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HREADY_I(hready), .HWDATA_I(hwdata),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .UNSTABLE_O(unstable),
        .SECOND_TICK_O(tick));
    rtc_bus_master_model bus_u (.clk_i(CLK_I), .hready_i(hready), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
        .hwdata_o(hwdata));
    // **********
    // checking and closing
    // **********
    task automatic check(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // oldest note vs each finished data phase
    always @(posedge CLK_I) begin
        if (pend && hready === 1'b1) begin
            note = notes.pop_front();
            check("hresp", {31'h0, hresp}, {31'h0, note[32]});
            if (note[33]) check("hrdata", hrdata, note[31:0]);
            pend = 1'b0;
        end
        if (hsel && htrans[1] && hready === 1'b1) pend = 1'b1;
    end
    // a hang counts as a mismatch
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // **********
    // driving tasks
    // **********
    // note, then transfer
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        notes.push_back({~w, e, d});
        bus_u.xfer(w, a, d);
    endtask : acc
    task automatic chk4(input logic [31:0] ym, dw, hm, s);
        acc(1'b0, YEAR_MONTH_ADDR, ym, 1'b0);
        acc(1'b0, DAY_WEEKDAY_ADDR, dw, 1'b0);
        acc(1'b0, HOUR_MINUTE_ADDR, hm, 1'b0);
        acc(1'b0, SECOND_ADDR, s, 1'b0);
    endtask : chk4
    // wait out the flag after a tick
    task automatic sync();
        @(posedge CLK_I iff tick === 1'b1);
        @(posedge CLK_I iff unstable === 1'b0);
    endtask : sync
    // **********
    // main sequence
    // **********
    initial begin
        repeat (20) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        @(posedge CLK_I);
        chk4(32'h1, 32'h1, 32'h0, 32'h0);
        acc(1'b1, SECOND_ADDR, 32'h5, 1'b0);
        acc(1'b0, SECOND_ADDR, 32'h5, 1'b0);
        acc(1'b0, 8'h18, 32'hFFFFFFFF, 1'b1);
        repeat (30) @(posedge CLK_I);
        acc(1'b1, SECOND_ADDR, 32'h9, 1'b1);
        acc(1'b1, 8'h1C, 32'h9, 1'b1);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, CONTROL_ADDR, 32'h1, 1'b0);
            acc(1'b1, CONTROL_ADDR, 32'h2, 1'b0);
            if (i == 0) acc(1'b1, STATE_ADDR, 32'h0, 1'b1);
            sync();
            if (i == 0) acc(1'b0, STATE_ADDR, 32'h2, 1'b0);
            r = $random(seed);
            yr = (i == 0) ? r[15:8] : yr_t[i];
            ny = (mo_t[i] == 4'hC) ? yr + 8'h1 : yr;
            wd = 3'(($random(seed) & 32'hFFFF) % 7);
            nwd = (wd == 3'h6) ? 3'h0 : wd + 3'h1;
            acc(1'b1, YEAR_MONTH_ADDR, {r[31:16], yr, r[7:4], mo_t[i]}, 1'b0);
            acc(1'b1, DAY_WEEKDAY_ADDR, {r[31:11], wd, r[7:5], dy_t[i]}, 1'b0);
            acc(1'b1, HOUR_MINUTE_ADDR, {r[31:13], 5'h17, r[7:6], 6'h3B}, 1'b0);
            acc(1'b1, SECOND_ADDR, {r[31:6], 6'h3B}, 1'b0);
            chk4({16'h0, yr, 4'h0, mo_t[i]}, {21'h0, wd, 3'h0, dy_t[i]},
                32'h173B, 32'h3B);
            sync();
            chk4({16'h0, ny, 4'h0, nm_t[i]}, {21'h0, nwd, 3'h0, nd_t[i]},
                32'h0, 32'h0);
        end
        // soft reset; code 0 relocks
        acc(1'b1, CONTROL_ADDR, 32'h100, 1'b0);
        chk4({16'h0, ny, 4'h0, nm_t[3]}, {21'h0, nwd, 3'h0, nd_t[3]},
            32'h0, 32'h0);
        acc(1'b0, STATE_ADDR, 32'h0, 1'b0);
        acc(1'b1, SECOND_ADDR, 32'h7, 1'b1);
        acc(1'b0, SECOND_ADDR, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule : tb_top
